/* hw/tsp_clk_block.v */
// One programmable clock block producing a one-cycle tick every div+1 source events
`timescale 1ns/1ps
`include "tsp_port_map.vh"

module tsp_clk_block (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // Configuration
  input  wire        src_pin_sel,
  input  wire [15:0] div,
  // Source pin level, already in the sys_clk domain
  input  wire        ext_level,
  // Tick out
  output reg         tick
);

  reg        ext_prev_r;
  reg [15:0] cnt_r;
  wire       src_event;

  // Pin source counts rising edges, internal source counts cycles
  assign src_event = src_pin_sel ? (ext_level & ~ext_prev_r) : 1'b1;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_prev_r <= 1'b0;
      cnt_r      <= 16'h0000;
      tick       <= 1'b0;
    end else begin
      ext_prev_r <= ext_level;
      if (src_event) begin
        if (cnt_r >= div) begin
          cnt_r <= 16'h0000;
          tick  <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
          tick  <= 1'b0;
        end
      end else begin
        tick <= 1'b0;
      end
    end
  end

endmodule

/* hw/tsp_port.v */
// Timed serializing I/O port with clock blocks and an AHB-Lite register slave
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tsp_port_map.vh"

// What this block does
// (R1) The port comes in widths 1, 4, 8, 16 or 32 and always runs at its own width.
// (R2) All pins of the port share one direction, all in or all out.
// (R3) Output drives pins high or low; input samples them, optionally waiting on a condition.
// (R4) Every core access to the port completes in one cycle.
// (R5) With open drain set, a zero pulls the pin low and a one leaves it floating.
// (R6) Data passes through a shift serializer and a transfer register.
// (R7) A 16-bit counter, readable any time, can delay a transfer until a target count.
// (R8) Each transfer captures the counter as a timestamp for software.
// (R9) An enabled inter-chip link on shared pins disconnects the port from them.
// (R10) An enabled narrower port wins the shared pins; unshared pins stay usable.
// (R11) Six clock blocks: block 0 is the 100MHz reference, the other five programmable.
// (R12) A clock block can take a 1-bit port pin as source and optionally divide it.
// (R13) An input strobe qualifies incoming data and an output strobe marks output data.
// (R14) After reset the port is attached to clock block 0.
// (R15) The port counter advances once per tick of its clock block, wrapping at 65536.
// (R16) A disabled or unconfigured port leaves its pins undriven.
module tsp_port #(
  parameter W  = 32,
  parameter TW = 32
) (
  // Clock and reset
  input  wire          sys_clk,
  input  wire          sys_rst,
  // AHB-Lite slave
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output wire          hreadyout,
  output wire          hresp,
  output reg  [31:0]   hrdata,
  // Pins
  input  wire [W-1:0]  pin_in,
  output reg  [W-1:0]  pin_out,
  output reg  [W-1:0]  pin_oe,
  // Pin sharing
  input  wire          link_en,
  input  wire [W-1:0]  narrow_claim,
  // External clock source pin of a 1-bit port
  input  wire          clk_src_pin,
  // Strobes
  input  wire          strobe_in_qualifier,
  output reg           strobe_out_qualifier,
  // Interrupt
  output wire          irq
);

  // (R1) Width W fixed per instance
  localparam SLICES = TW / W;
  localparam SW     = 6;

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  function pick_tick;
    input [2:0] sel;
    input [5:0] ticks;
    begin
      if (sel < 3'd6) begin
        pick_tick = ticks[sel];
      end else begin
        pick_tick = 1'b0;
      end
    end
  endfunction

  function clk_reg_hit;
    input [7:0] a;
    begin
      clk_reg_hit = (a >= `TSP_REG_CLK_BASE) && (a <= `TSP_REG_CLK_LAST) &&
                    (a[1:0] == 2'b00);
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [31:0]             ctrl_r;
  reg  [W-1:0]            cond_r;
  reg  [`TSP_CNT_W-1:0]   target_r;
  reg                     timed_armed_r;
  reg  [`TSP_CNT_W-1:0]   cnt_r;
  reg  [`TSP_CNT_W-1:0]   stamp_r;
  reg  [2:0]              status_r;
  reg  [2:0]              mask_r;
  reg  [`TSP_CLK_CFG_W-1:0] clkcfg_r [1:5];
  reg  [TW-1:0]           tx_sr_r;
  reg  [TW-1:0]           rx_sr_r;
  reg  [TW-1:0]           rx_data_r;
  reg  [W-1:0]            out_val_r;
  reg                     out_busy_r;
  reg  [SW-1:0]           slice_r;
  reg                     wr_pend_r;
  reg  [7:0]              wr_addr_r;
  reg  [2:0]              st_set;
  reg  [2:0]              st_nxt;
  reg  [31:0]             cond_word;
  reg  [TW-1:0]           pin_word;
  integer                 k;

  wire [5:0]              ticks;
  wire                    port_tick;
  wire                    addr_take;
  wire [7:0]              a_lo;
  wire                    rd_take;
  wire                    en;
  wire                    dir_out;
  wire                    od;
  wire [SW-1:0]           slice_max;
  wire                    time_ok;
  wire                    in_ok;
  wire                    out_go;
  wire                    in_go;
  wire                    last_slice;
  wire [TW-1:0]           tx_shift;
  wire [TW-1:0]           rx_shift;
  wire                    data_wr;

  assign en        = ctrl_r[`TSP_CTRL_EN];
  assign dir_out   = ctrl_r[`TSP_CTRL_DIR_OUT];
  assign od        = ctrl_r[`TSP_CTRL_OD];
  assign slice_max = ctrl_r[`TSP_CTRL_SERIAL] ? SLICES[SW-1:0] : {{(SW-1){1'b0}}, 1'b1};

  // --------------------------------------------------------------------------
  // Clock blocks
  // --------------------------------------------------------------------------
  // (R11) Block 0 is the reference
  assign ticks[0] = 1'b1;

  genvar g;
  generate
    for (g = 1; g < `TSP_NUM_CLK_BLOCKS; g = g + 1) begin : g_clk
      // (R12) Pin source with divide
      tsp_clk_block u_blk (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .src_pin_sel (clkcfg_r[g][`TSP_CLK_SRC_PIN]),
        .div         (clkcfg_r[g][`TSP_CLK_DIV_HI:0]),
        .ext_level   (clk_src_pin),
        .tick        (ticks[g])
      );
    end
  endgenerate

  assign port_tick = pick_tick(ctrl_r[`TSP_CTRL_CLK_HI:`TSP_CTRL_CLK_LO], ticks);

  // --------------------------------------------------------------------------
  // Shift paths
  // --------------------------------------------------------------------------
  // (R6) Serializer shift paths
  generate
    if (W == TW) begin : g_full
      assign tx_shift = {TW{1'b0}};
      assign rx_shift = pin_in;
    end else begin : g_part
      assign tx_shift = {{W{1'b0}}, tx_sr_r[TW-1:W]};
      assign rx_shift = {pin_in, rx_sr_r[TW-1:W]};
    end
  endgenerate

  // (R7) Hold off until target count
  assign time_ok    = ~timed_armed_r | (cnt_r == target_r);
  // (R3) Wait for pin condition
  assign in_ok      = (~ctrl_r[`TSP_CTRL_COND] | (pin_in == cond_r)) &
                      (~ctrl_r[`TSP_CTRL_STROBE] | strobe_in_qualifier);
  assign out_go     = en & dir_out & out_busy_r & port_tick & time_ok;
  // (R13) Strobe qualifies input
  assign in_go      = en & ~dir_out & port_tick & time_ok & in_ok;
  assign last_slice = (slice_r + {{(SW-1){1'b0}}, 1'b1}) >= slice_max;
  // Zero-extended views, also legal at full width
  always @* begin
    cond_word        = 32'h0000_0000;
    cond_word[W-1:0] = cond_r;
    pin_word         = {TW{1'b0}};
    pin_word[W-1:0]  = pin_in;
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  // (R4) Zero wait state access
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_take = hsel & htrans[1] & hready;
  assign a_lo      = haddr[7:0];
  assign rd_take   = addr_take & ~hwrite;
  assign data_wr   = wr_pend_r & (wr_addr_r == `TSP_REG_DATA);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata    <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_take & hwrite;
      wr_addr_r <= a_lo;
      if (rd_take) begin
        case (a_lo)
          `TSP_REG_CTRL:   hrdata <= ctrl_r;
          `TSP_REG_DATA:   hrdata <= rx_data_r;
          `TSP_REG_COND:   hrdata <= cond_word;
          // (R7) Counter readable any time
          `TSP_REG_TIME:   hrdata <= {16'h0000, cnt_r};
          `TSP_REG_STAMP:  hrdata <= {16'h0000, stamp_r};
          `TSP_REG_STATUS: hrdata <= {28'h000_0000, out_busy_r, status_r};
          `TSP_REG_MASK:   hrdata <= {29'h0000_0000, mask_r};
          default: begin
            if (clk_reg_hit(a_lo)) begin
              hrdata <= {15'h0000, clkcfg_r[a_lo[4:2] + 3'd1]};
            end else begin
              hrdata <= 32'h0000_0000;
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      // (R14) Reset selects block 0
      ctrl_r   <= `TSP_CTRL_RST;
      cond_r   <= {W{1'b0}};
      target_r <= `TSP_CNT_RST;
      mask_r   <= `TSP_MASK_RST;
      for (k = 1; k < `TSP_NUM_CLK_BLOCKS; k = k + 1) begin
        clkcfg_r[k] <= `TSP_CLK_CFG_RST;
      end
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        `TSP_REG_CTRL: ctrl_r   <= {21'h00_0000, hwdata[10:8], 1'b0, hwdata[6:0]};
        `TSP_REG_COND: cond_r   <= hwdata[W-1:0];
        `TSP_REG_TIME: target_r <= hwdata[`TSP_CNT_W-1:0];
        `TSP_REG_MASK: mask_r   <= hwdata[2:0];
        default: begin
          if (clk_reg_hit(wr_addr_r)) begin
            clkcfg_r[wr_addr_r[4:2] + 3'd1] <= hwdata[`TSP_CLK_CFG_W-1:0];
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Counter, timestamp and transfers
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_r         <= `TSP_CNT_RST;
      stamp_r       <= `TSP_CNT_RST;
      timed_armed_r <= 1'b0;
      tx_sr_r       <= {TW{1'b0}};
      rx_sr_r       <= {TW{1'b0}};
      rx_data_r     <= {TW{1'b0}};
      out_val_r     <= {W{1'b0}};
      out_busy_r    <= 1'b0;
      slice_r       <= {SW{1'b0}};
      strobe_out_qualifier <= 1'b0;
    end else begin
      // (R15) Advance per tick, wrap
      if (port_tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      strobe_out_qualifier <= 1'b0;
      if (out_go) begin
        // (R3) Drive next slice
        out_val_r            <= tx_sr_r[W-1:0];
        tx_sr_r              <= tx_shift;
        // (R13) Strobe marks output
        strobe_out_qualifier <= 1'b1;
        timed_armed_r        <= 1'b0;
        if (slice_r == {SW{1'b0}}) begin
          // (R8) Stamp first slice
          stamp_r <= cnt_r;
        end
        if (last_slice) begin
          out_busy_r <= 1'b0;
          slice_r    <= {SW{1'b0}};
        end else begin
          slice_r <= slice_r + {{(SW-1){1'b0}}, 1'b1};
        end
      end else if (in_go) begin
        // (R3) Sample pins
        rx_sr_r       <= rx_shift;
        timed_armed_r <= 1'b0;
        if (last_slice) begin
          // (R8) Stamp on completion
          stamp_r <= cnt_r;
          slice_r <= {SW{1'b0}};
          if (ctrl_r[`TSP_CTRL_SERIAL]) begin
            rx_data_r <= rx_shift;
          end else begin
            rx_data_r <= pin_word;
          end
        end else begin
          slice_r <= slice_r + {{(SW-1){1'b0}}, 1'b1};
        end
      end
      // (R6) Transfer register load
      if (data_wr && !out_busy_r) begin
        tx_sr_r    <= hwdata[TW-1:0];
        out_busy_r <= 1'b1;
        slice_r    <= {SW{1'b0}};
      end
      // (R7) Arm target count
      if (wr_pend_r && (wr_addr_r == `TSP_REG_TIME)) begin
        timed_armed_r <= ctrl_r[`TSP_CTRL_TIMED];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event status and interrupt
  // --------------------------------------------------------------------------
  always @* begin
    st_set = 3'b000;
    st_set[`TSP_ST_IN_READY] = in_go & last_slice;
    st_set[`TSP_ST_OUT_DONE] = out_go & last_slice;
    st_set[`TSP_ST_COND_MET] = in_go & ctrl_r[`TSP_CTRL_COND];
    st_nxt = status_r;
    if (rd_take && (a_lo == `TSP_REG_STATUS)) begin
      st_nxt = 3'b000;
    end
    st_nxt = st_nxt | st_set;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      status_r <= 3'b000;
    end else begin
      status_r <= st_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_out <= {W{1'b0}};
      pin_oe  <= {W{1'b0}};
    end else begin
      // (R5) Open drain only pulls low
      pin_out <= od ? {W{1'b0}} : out_val_r;
      // (R2) One direction for all pins
      // (R9) Link takes pins; (R10) narrower port wins; (R16) disabled port floats
      if (en && dir_out && !link_en) begin
        pin_oe <= ~narrow_claim & (od ? ~out_val_r : {W{1'b1}});
      end else begin
        pin_oe <= {W{1'b0}};
      end
    end
  end

endmodule

/* hw/tsp_port_map.vh */
// Register map, field positions, reset values and timing counts of the timed port
`ifndef TSP_PORT_MAP_VH
`define TSP_PORT_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define TSP_REG_CTRL       8'h00
`define TSP_REG_DATA       8'h04
`define TSP_REG_COND       8'h08
`define TSP_REG_TIME       8'h0C
`define TSP_REG_STAMP      8'h10
`define TSP_REG_STATUS     8'h14
`define TSP_REG_MASK       8'h18
`define TSP_REG_CLK_BASE   8'h20
`define TSP_REG_CLK_LAST   8'h30

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define TSP_CTRL_EN        0
`define TSP_CTRL_DIR_OUT   1
`define TSP_CTRL_OD        2
`define TSP_CTRL_COND      3
`define TSP_CTRL_TIMED     4
`define TSP_CTRL_STROBE    5
`define TSP_CTRL_SERIAL    6
`define TSP_CTRL_CLK_LO    8
`define TSP_CTRL_CLK_HI    10
`define TSP_CTRL_RST       32'h0000_0000

// ----------------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------------
`define TSP_ST_IN_READY    0
`define TSP_ST_OUT_DONE    1
`define TSP_ST_COND_MET    2
`define TSP_ST_OUT_BUSY    3
`define TSP_ST_EVENTS      3
`define TSP_MASK_RST       3'h0

// ----------------------------------------------------------------------------
// Clock block configuration fields
// ----------------------------------------------------------------------------
`define TSP_CLK_DIV_HI     15
`define TSP_CLK_SRC_PIN    16
`define TSP_CLK_CFG_W      17
`define TSP_CLK_CFG_RST    17'h0_0000

// ----------------------------------------------------------------------------
// Clocking and counts
// ----------------------------------------------------------------------------
`define TSP_NUM_CLK_BLOCKS 6
`define TSP_REF_CLK_MHZ    100
`define TSP_SYS_CLK_MHZ    100
`define TSP_REF_DIV        (`TSP_SYS_CLK_MHZ / `TSP_REF_CLK_MHZ)
`define TSP_CNT_W          16
`define TSP_CNT_RST        16'h0000

`endif

/* verif/tsp_pin_model.sv */
// Application hardware on the port pins: input driver, source clock, slice log
`timescale 1ns/1ps

module tsp_pin_model #(
  parameter W = 8
) (
  // Clock
  input  wire logic         sys_clk,
  // Port side
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic         strobe_out_qualifier,
  output wire logic [W-1:0] pin_in,
  output logic              strobe_in_qualifier,
  output logic              clk_src_pin
);
  logic [W-1:0] ext_v = '0;
  logic [W-1:0] slices [$];
  logic         stb_seen = 1'b0;

  initial strobe_in_qualifier = 1'b0;
  initial clk_src_pin = 1'b0;

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_v);

  always @(posedge sys_clk) begin
    if (stb_seen) begin
      slices.push_back(pin_out);
    end
    stb_seen <= strobe_out_qualifier;
  end

  // source clock only runs on request
  task automatic pulse(input int n);
    repeat (2 * n) begin
      repeat (3) @(posedge sys_clk);
      clk_src_pin <= ~clk_src_pin;
    end
  endtask
endmodule

/* verif/tsp_port_monitor.sv */
// Concurrent checks on the timed port bus, pin and strobe outputs
`timescale 1ns/1ps
`include "tsp_port_map.vh"

module tsp_port_monitor #(
  parameter W = 32
) (
  // Clock and reset
  input wire logic         sys_clk,
  input wire logic         sys_rst,
  // Bus
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic         hready,
  input wire logic         hreadyout,
  input wire logic         hresp,
  input wire logic [31:0]  hrdata,
  // Pins and strobes
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic         link_en,
  input wire logic [W-1:0] narrow_claim,
  input wire logic         strobe_out_qualifier,
  input wire logic         irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  wire rd_take = hsel & htrans[1] & hready & ~hwrite;
  wire hole    = (haddr[7:0] == 8'h1C) | (haddr[7:0] > `TSP_REG_CLK_LAST);

  // ----------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------
  sequence s_read_taken;
    rd_take;
  endsequence
  sequence s_hole_read;
    s_read_taken ##0 (hole && haddr[1:0] == 2'h0);
  endsequence

  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("slave answered with an error");
  a_read_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_hole_zero: assert property (s_hole_read |=> hrdata == 32'h0000_0000)
    else $error("unmapped read gave nonzero data");
  a_link_release: assert property (link_en [*2] |-> pin_oe == '0)
    else $error("port drives pins owned by the link");
  a_narrow_yield: assert property (
    (narrow_claim != '0) && $stable(narrow_claim) |-> (pin_oe & narrow_claim) == '0)
    else $error("port drives pins claimed by a narrower port");
  a_reset_pins: assert property ($past(sys_rst) |-> pin_oe == '0 && pin_out == '0)
    else $error("pins driven right after reset");
  a_reset_flags: assert property (
    $past(sys_rst) |-> !strobe_out_qualifier && !irq && hrdata == 32'h0000_0000)
    else $error("strobe, interrupt or read data set after reset");
endmodule

bind tsp_port tsp_port_monitor #(.W(W)) mon_u (
  .sys_clk              (sys_clk),
  .sys_rst              (sys_rst),
  .hsel                 (hsel),
  .haddr                (haddr),
  .htrans               (htrans),
  .hwrite               (hwrite),
  .hready               (hready),
  .hreadyout            (hreadyout),
  .hresp                (hresp),
  .hrdata               (hrdata),
  .pin_out              (pin_out),
  .pin_oe               (pin_oe),
  .link_en              (link_en),
  .narrow_claim         (narrow_claim),
  .strobe_out_qualifier (strobe_out_qualifier),
  .irq                  (irq)
);

/* verif/tsp_port_tb.sv */
// Register-level testbench of the timed port
`timescale 1ns/1ps
`include "tsp_port_map.vh"

module tsp_port_tb;
  localparam W = 8;
  logic         sys_clk      = 1'b0;
  logic         sys_rst      = 1'b1;
  logic         hsel         = 1'b0;
  logic [31:0]  haddr        = 32'h0000_0000;
  logic [1:0]   htrans       = 2'h0;
  logic         hwrite       = 1'b0;
  logic [31:0]  hwdata       = 32'h0000_0000;
  logic         link_en      = 1'b0;
  logic [W-1:0] narrow_claim = 8'h00;
  wire          hreadyout;
  wire          hresp;
  wire [31:0]   hrdata;
  wire [W-1:0]  pin_in;
  wire [W-1:0]  pin_out;
  wire [W-1:0]  pin_oe;
  wire          clk_src_pin;
  wire          stb_in;
  wire          strobe_out_qualifier;
  wire          irq;
  int           fail_count   = 0;
  int           check_count  = 0;
  logic [31:0]  rd;
  logic [31:0]  t0;
  logic [7:0]   rst_addr [6] = '{`TSP_REG_CTRL, `TSP_REG_MASK, `TSP_REG_STATUS,
                                 `TSP_REG_CLK_BASE, `TSP_REG_CLK_LAST, 8'h1C};

  always #5 sys_clk = ~sys_clk;

  tsp_port #(.W(W), .TW(32)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .link_en(link_en), .narrow_claim(narrow_claim),
    .clk_src_pin(clk_src_pin), .strobe_in_qualifier(stb_in),
    .strobe_out_qualifier(strobe_out_qualifier), .irq(irq));

  tsp_pin_model #(.W(W)) pm_u (
    .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .strobe_out_qualifier(strobe_out_qualifier), .pin_in(pin_in),
    .strobe_in_qualifier(stb_in), .clk_src_pin(clk_src_pin));

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd);
  endtask

  task automatic wstb();
    int n;
    n = 0;
    while (strobe_out_qualifier !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("strobe", 32'h1, {31'h0, strobe_out_qualifier});
    @(posedge sys_clk);
  endtask

  function automatic logic [31:0] pins();
    return {16'h0, pin_oe, pin_out};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rst_addr[i]) rchk(rst_addr[i], 32'h0);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rchk(8'h1C, 32'h0);
    bus(1'b1, `TSP_REG_CTRL, 32'h3);
    bus(1'b1, `TSP_REG_MASK, 32'h2);
    bus(1'b0, `TSP_REG_TIME, 32'h0);
    t0 = rd;
    bus(1'b0, `TSP_REG_TIME, 32'h0);
    chk("count step", 32'h2, (rd - t0) & 32'hFFFF);
    bus(1'b1, `TSP_REG_DATA, 32'hA5);
    wstb();
    chk("pins", 32'h0000_FFA5, pins());
    chk("irq set", 32'h1, {31'h0, irq});
    rchk(`TSP_REG_STATUS, 32'h2);
    chk("irq clear", 32'h0, {31'h0, irq});
    bus(1'b1, `TSP_REG_MASK, 32'h0);
    bus(1'b1, `TSP_REG_DATA, 32'h5A);
    wstb();
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `TSP_REG_CTRL, 32'h7);
    bus(1'b1, `TSP_REG_DATA, 32'h0F);
    wstb();
    chk("open drain", 32'h0000_F000, pins());
    narrow_claim <= 8'h30;
    repeat (3) @(posedge sys_clk);
    chk("narrow", 32'h0000_C000, pins());
    narrow_claim <= 8'h00;
    link_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("link", 32'h0, pins());
    link_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("restore", 32'h0000_F000, pins());
    bus(1'b1, `TSP_REG_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("off", 32'h0, {24'h0, pin_oe});
    bus(1'b1, `TSP_REG_CTRL, 32'h43);
    pm_u.slices.delete();
    bus(1'b1, `TSP_REG_DATA, 32'h4433_2211);
    repeat (12) @(posedge sys_clk);
    chk("slice count", 32'h4, 32'(pm_u.slices.size()));
    chk("slices", 32'h4433_2211,
        {pm_u.slices[3], pm_u.slices[2], pm_u.slices[1], pm_u.slices[0]});
    bus(1'b1, `TSP_REG_CTRL, 32'h13);
    bus(1'b0, `TSP_REG_TIME, 32'h0);
    t0 = (rd + 32'd40) & 32'hFFFF;
    bus(1'b1, `TSP_REG_TIME, t0);
    bus(1'b1, `TSP_REG_DATA, 32'h81);
    wstb();
    rchk(`TSP_REG_STAMP, t0);
    pm_u.ext_v <= 8'h5A;
    bus(1'b1, `TSP_REG_CTRL, 32'h1);
    repeat (3) @(posedge sys_clk);
    rchk(`TSP_REG_DATA, 32'h5A);
    bus(1'b1, `TSP_REG_COND, 32'h3C);
    pm_u.ext_v <= 8'h11;
    bus(1'b1, `TSP_REG_CTRL, 32'h9);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, `TSP_REG_STATUS, 32'h0);
    rchk(`TSP_REG_STATUS, 32'h0);
    pm_u.ext_v <= 8'h3C;
    repeat (3) @(posedge sys_clk);
    rchk(`TSP_REG_STATUS, 32'h5);
    rchk(`TSP_REG_DATA, 32'h3C);
    pm_u.ext_v <= 8'h77;
    bus(1'b1, `TSP_REG_CTRL, 32'h21);
    repeat (3) @(posedge sys_clk);
    rchk(`TSP_REG_DATA, 32'h3C);
    pm_u.strobe_in_qualifier <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rchk(`TSP_REG_DATA, 32'h77);
    pm_u.strobe_in_qualifier <= 1'b0;
    for (int n = 1; n <= 5; n++) begin
      bus(1'b1, `TSP_REG_CLK_BASE + 8'(4 * (n - 1)), {15'h0, 1'b1, 16'(n - 1)});
      bus(1'b1, `TSP_REG_CTRL, 32'h1 | (32'(n) << 8));
      bus(1'b0, `TSP_REG_TIME, 32'h0);
      t0 = rd;
      pm_u.pulse(n * n);
      repeat (4) @(posedge sys_clk);
      bus(1'b0, `TSP_REG_TIME, 32'h0);
      chk("block ticks", 32'(n), (rd - t0) & 32'hFFFF);
    end
    final_report();
  end
endmodule
